//--- usic_pkg.sv
// Constants, field layouts and carrier types for the interrupt and suspend control block
package usic_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] SYS_CTRL_INDEX = 8'h11;
   localparam logic [7:0] SYS_STATUS_INDEX = 8'h12;
   localparam logic [7:0] INT_STATUS_INDEX = 8'h1c;
   localparam logic [7:0] INT_MASK_INDEX = 8'h1d;

   localparam logic [7:0] SYS_CTRL_ADDR = {SYS_CTRL_INDEX[5:0], 2'b00};
   localparam logic [7:0] SYS_STATUS_ADDR = {SYS_STATUS_INDEX[5:0], 2'b00};
   localparam logic [7:0] INT_STATUS_ADDR = {INT_STATUS_INDEX[5:0], 2'b00};
   localparam logic [7:0] INT_MASK_ADDR = {INT_MASK_INDEX[5:0], 2'b00};

   // System control field positions
   localparam int CTRL_POLARITY_BIT = 7;
   localparam int CTRL_SUSP_IE_BIT = 5;
   localparam int CTRL_RESET_IE_BIT = 4;
   localparam int CTRL_PULSE_BIT = 2;
   localparam int CTRL_GLOBAL_EN_BIT = 1;

   // System status field positions
   localparam int STAT_POWER_OFF_BIT = 4;
   localparam int STAT_DET_DIS_BIT = 3;
   localparam int STAT_SUSPEND_BIT = 1;
   localparam int STAT_RESET_BIT = 0;

   // Interrupt status and mask layout
   localparam int INT_W = 2;
   localparam int INT_RESET_BIT = 0;
   localparam int INT_SUSPEND_BIT = 1;

   // Values after reset
   localparam logic [7:0] SYS_STATUS_RESET = 8'h00;
   localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
   localparam logic [INT_W-1:0] INT_STATUS_RESET = 2'h0;
   localparam logic [INT_W-1:0] INT_MASK_RESET = 2'h0;
   localparam logic PIN_RESET = 1'b1;

   // Pulse length in core clock periods
   localparam int PULSE_TCLK = 2;
   localparam logic [1:0] PULSE_CYCLES = 2'(PULSE_TCLK);

   // AHB-Lite encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef struct packed {
      logic irqPolaritySelect;
      logic suspendIrqEnable;
      logic usbResetIrqEnable;
      logic irqPulseSelect;
      logic globalIrqEnable;
   } usic_ctrl_t;

   typedef struct packed {
      logic irqPulseSelect;
      logic irqPolaritySelect;
   } usic_irq_cfg_t;

endpackage : usic_pkg

//--- usic_irq_out.sv
// Interrupt pin driver with level or pulse mode and selectable polarity
`timescale 1ns/1ps
module usic_irq_out
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic srcLevel,
   input wire usic_pkg::usic_irq_cfg_t cfg,
   output logic interruptOutputPin
);
   import usic_pkg::*;

   logic srcPrevFf;
   logic [1:0] pulseCntFf;
   logic pinFf;
   logic [1:0] nxt_pulseCnt;
   logic nxt_pin;
   logic rise;
   logic irqActive;
   logic pinActive;

   // Pulse only on a new source edge
   assign rise = srcLevel && !srcPrevFf; // [RL15]
   assign nxt_pulseCnt = (cfg.irqPulseSelect && rise) ? PULSE_CYCLES :
      (pulseCntFf != 2'h0) ? pulseCntFf - 2'h1 : 2'h0; // [RL2]
   // Level follows source, pulse follows counter
   assign irqActive = cfg.irqPulseSelect ? (pulseCntFf != 2'h0) : srcLevel; // [RL1] [RL14]
   assign nxt_pin = cfg.irqPolaritySelect ? irqActive : !irqActive; // [RL11]
   assign interruptOutputPin = pinFf;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         srcPrevFf <= 1'b0;
         pulseCntFf <= 2'h0;
         pinFf <= PIN_RESET;
      end
      else if (clkEn)
      begin
         srcPrevFf <= srcLevel;
         pulseCntFf <= nxt_pulseCnt;
         pinFf <= nxt_pin;
      end
   end

   assign pinActive = (pinFf == cfg.irqPolaritySelect);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst || !clkEn);

   pulse_width_a: assert property ( // [RL2]
      (cfg.irqPulseSelect && rise && $stable(cfg)) ##1 $stable(cfg) [*3]
      |-> pinActive && $past(pinActive, 1))
      else $error("Pulse not two cycles long");

   pulse_idle_a: assert property ( // [RL15]
      (cfg.irqPulseSelect && pulseCntFf == 2'h0 && !rise) ##1 $stable(cfg) |-> !pinActive)
      else $error("Pulse without a new source edge");

   level_follow_a: assert property ( // [RL14]
      (!cfg.irqPulseSelect) ##1 $stable(cfg) |-> pinActive == $past(srcLevel))
      else $error("Level mode pin does not follow source");

   pulse_mode_a: assert property ( // [RL1]
      (cfg.irqPulseSelect && srcLevel && srcPrevFf && pulseCntFf == 2'h0) ##1 $stable(cfg)
      |-> !pinActive)
      else $error("Pulse mode held pin active on a steady source");

   polarity_a: assert property ( // [RL11]
      (!irqActive) |=> interruptOutputPin == !$past(cfg.irqPolaritySelect))
      else $error("Inactive pin level wrong for polarity");

endmodule : usic_irq_out

//--- usic_irq_suspend_control.sv
// Interrupt signalling and suspend control registers with an AHB-Lite slave
//
// Summary of operation
// (RL1) A cleared pulse-select bit gives a level interrupt pin, a set one a pulse pin.
// (RL2) In pulse mode the pin is held active for exactly two clock periods per event.
// (RL3) With global enable set, endpoint or missed-frame flags, and reset or suspend flags with their own enables, raise the pin.
// (RL4) Bit 0 of the system control register is written as zero and always reads zero.
// (RL5) The system status register sits at index 0x12 and resets to all zeros.
// (RL6) Status bits 7 to 5 are written as zero and always read zero.
// (RL7) Software sets suspend power-off when attached devices lose power in suspend.
// (RL8) Software programs suspend power-off before commanding suspend, normally once.
// (RL9) While suspend-detect disable is set, bus suspend is neither detected nor flagged.
// (RL10) Suspend-detect disable is for test and software normally leaves it clear.
// (RL11) A set polarity bit makes the pin active high, a clear one active low.
// (RL13) A bus reset sets the reset flag, which interrupts when enabled, and software clears it.
// (RL14) In level mode the pin stays active while an enabled flag is set.
// (RL15) In pulse mode each new rising source flag gives one pulse.
`timescale 1ns/1ps
module usic_irq_suspend_control
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic epTxRxFlag,
   input wire logic missedFrameStartFlag,
   input wire logic usbResetDetect,
   input wire logic suspendCondition,
   output logic interruptOutputPin,
   output logic sysIrq,
   output logic suspendPowerOff,
   output logic suspendCommand
);
   import usic_pkg::*;

   // Bus pipeline state
   logic [7:0] addrFf;
   logic wrPhaseFf;
   logic rdPhaseFf;
   logic [31:0] hrdataFf;

   // Register state
   usic_ctrl_t ctrlFf;
   logic suspendPowerOffFf;
   logic suspendDetectDisableFf;
   logic suspendCtrlFf;
   logic resetFlagFf;
   logic suspendFlagFf;
   logic suspendCommandFf;
   logic [INT_W-1:0] intStatusFf;
   logic [INT_W-1:0] intMaskFf;

   // Next values
   usic_ctrl_t nxt_ctrl;
   logic nxt_suspendPowerOff;
   logic nxt_suspendDetectDisable;
   logic nxt_suspendCtrl;
   logic nxt_resetFlag;
   logic nxt_suspendFlag;
   logic nxt_suspendCommand;
   logic [INT_W-1:0] nxt_intStatus;
   logic [INT_W-1:0] nxt_intMask;

   // Decode
   logic addrPhase;
   logic accessOk;
   logic rdAccess;
   logic wrCtrl;
   logic wrStatus;
   logic wrMask;
   logic rdIntClear;
   logic [7:0] ctrlByte;
   logic [7:0] statusByte;
   logic [31:0] rdValue;
   logic [INT_W-1:0] intEvents;
   logic suspendEvent;
   logic irqSource;
   usic_irq_cfg_t irqCfg;

   assign addrPhase = hsel && htrans[1] && hready;
   assign accessOk = addrPhase && (hsize == HSIZE_WORD) && (haddr[1:0] == 2'b00);
   assign rdAccess = accessOk && !hwrite;
   assign wrCtrl = wrPhaseFf && (addrFf == SYS_CTRL_ADDR);
   assign wrStatus = wrPhaseFf && (addrFf == SYS_STATUS_ADDR);
   assign wrMask = wrPhaseFf && (addrFf == INT_MASK_ADDR);
   assign rdIntClear = rdAccess && (haddr[7:0] == INT_STATUS_ADDR);

   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdataFf;

   // Readback images, reserved bits as zero
   assign ctrlByte = {ctrlFf.irqPolaritySelect, 1'b0, ctrlFf.suspendIrqEnable,
      ctrlFf.usbResetIrqEnable, 1'b0, ctrlFf.irqPulseSelect,
      ctrlFf.globalIrqEnable, 1'b0}; // [RL4]
   assign statusByte = {3'b000, suspendPowerOffFf, suspendDetectDisableFf, 1'b0,
      suspendFlagFf, resetFlagFf}; // [RL6]

   always_comb
   begin
      rdValue = 32'h0000_0000;
      if (haddr[7:0] == SYS_CTRL_ADDR)
      begin
         rdValue = {24'h00_0000, ctrlByte};
      end
      else if (haddr[7:0] == SYS_STATUS_ADDR)
      begin
         rdValue = {24'h00_0000, statusByte}; // [RL5]
      end
      else if (haddr[7:0] == INT_STATUS_ADDR)
      begin
         rdValue = {30'h0000_0000, intStatusFf};
      end
      else if (haddr[7:0] == INT_MASK_ADDR)
      begin
         rdValue = {30'h0000_0000, intMaskFf};
      end
   end

   // Control register writes
   assign nxt_ctrl = wrCtrl ? '{irqPolaritySelect: hwdata[CTRL_POLARITY_BIT],
      suspendIrqEnable: hwdata[CTRL_SUSP_IE_BIT],
      usbResetIrqEnable: hwdata[CTRL_RESET_IE_BIT],
      irqPulseSelect: hwdata[CTRL_PULSE_BIT],
      globalIrqEnable: hwdata[CTRL_GLOBAL_EN_BIT]} : ctrlFf;

   // Status register writes and hardware flags
   assign nxt_suspendPowerOff = wrStatus ? hwdata[STAT_POWER_OFF_BIT] : suspendPowerOffFf;
   assign nxt_suspendDetectDisable = wrStatus ? hwdata[STAT_DET_DIS_BIT] :
      suspendDetectDisableFf;
   assign nxt_suspendCtrl = wrStatus ? hwdata[STAT_SUSPEND_BIT] : suspendCtrlFf;
   assign nxt_suspendCommand = wrStatus && !hwdata[STAT_SUSPEND_BIT] && suspendCtrlFf;
   assign nxt_suspendFlag = suspendCondition && !suspendDetectDisableFf; // [RL9]
   assign nxt_resetFlag = usbResetDetect ||
      (resetFlagFf && !(wrStatus && !hwdata[STAT_RESET_BIT])); // [RL13]

   // Sticky events, read clears, new event wins
   assign suspendEvent = nxt_suspendFlag && !suspendFlagFf;
   assign intEvents = {suspendEvent, usbResetDetect};
   assign nxt_intStatus = (rdIntClear ? INT_STATUS_RESET : intStatusFf) | intEvents;
   assign nxt_intMask = wrMask ? hwdata[INT_W-1:0] : intMaskFf;
   assign sysIrq = |(intStatusFf & intMaskFf);

   // Pin source gathering
   assign irqSource = ctrlFf.globalIrqEnable && (epTxRxFlag || missedFrameStartFlag ||
      (resetFlagFf && ctrlFf.usbResetIrqEnable) ||
      (suspendFlagFf && ctrlFf.suspendIrqEnable)); // [RL3] [RL13]
   assign irqCfg = '{irqPulseSelect: ctrlFf.irqPulseSelect,
      irqPolaritySelect: ctrlFf.irqPolaritySelect};

   assign suspendPowerOff = suspendPowerOffFf;
   assign suspendCommand = suspendCommandFf;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         addrFf <= 8'h00;
         wrPhaseFf <= 1'b0;
         rdPhaseFf <= 1'b0;
         hrdataFf <= 32'h0000_0000;
      end
      else if (clkEn)
      begin
         addrFf <= accessOk ? haddr[7:0] : addrFf;
         wrPhaseFf <= accessOk && hwrite;
         rdPhaseFf <= rdAccess;
         hrdataFf <= rdAccess ? rdValue : hrdataFf;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ctrlFf <= usic_ctrl_t'(SYS_CTRL_RESET[4:0]);
         suspendPowerOffFf <= SYS_STATUS_RESET[STAT_POWER_OFF_BIT]; // [RL5]
         suspendDetectDisableFf <= SYS_STATUS_RESET[STAT_DET_DIS_BIT];
         suspendCtrlFf <= SYS_STATUS_RESET[STAT_SUSPEND_BIT];
         resetFlagFf <= SYS_STATUS_RESET[STAT_RESET_BIT];
         suspendFlagFf <= SYS_STATUS_RESET[STAT_SUSPEND_BIT];
         suspendCommandFf <= 1'b0;
      end
      else if (clkEn)
      begin
         ctrlFf <= nxt_ctrl;
         suspendPowerOffFf <= nxt_suspendPowerOff;
         suspendDetectDisableFf <= nxt_suspendDetectDisable;
         suspendCtrlFf <= nxt_suspendCtrl;
         resetFlagFf <= nxt_resetFlag;
         suspendFlagFf <= nxt_suspendFlag;
         suspendCommandFf <= nxt_suspendCommand;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         intStatusFf <= INT_STATUS_RESET;
         intMaskFf <= INT_MASK_RESET;
      end
      else if (clkEn)
      begin
         intStatusFf <= nxt_intStatus;
         intMaskFf <= nxt_intMask;
      end
   end

   // Pin driver
   usic_irq_out u_irq_out
   (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .srcLevel(irqSource),
      .cfg(irqCfg),
      .interruptOutputPin(interruptOutputPin)
   );

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst || !clkEn);

   status_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0) // [RL5]
      sys_rst |=> (statusByte == SYS_STATUS_RESET) && (interruptOutputPin == PIN_RESET))
      else $error("Status register not cleared by reset");

   ctrl_rsvd_a: assert property ( // [RL4]
      (rdPhaseFf && addrFf == SYS_CTRL_ADDR) |-> (hrdata[0] == 1'b0))
      else $error("Control reserved bit read nonzero");

   status_rsvd_a: assert property ( // [RL6]
      (rdPhaseFf && addrFf == SYS_STATUS_ADDR) |-> (hrdata[7:5] == 3'b000))
      else $error("Status reserved bits read nonzero");

   reset_flag_a: assert property ( // [RL13]
      usbResetDetect |=> resetFlagFf && intStatusFf[INT_RESET_BIT])
      else $error("Bus reset did not set flags");

   reset_hold_a: assert property ( // [RL13]
      (resetFlagFf && !wrStatus) |=> resetFlagFf)
      else $error("Reset flag cleared without a write");

   suspend_dis_a: assert property ( // [RL9]
      suspendDetectDisableFf |=> !suspendFlagFf && !intStatusFf[INT_SUSPEND_BIT] ||
      $past(intStatusFf[INT_SUSPEND_BIT]))
      else $error("Suspend flagged while detection disabled");

   global_en_a: assert property ( // [RL3]
      (ctrlFf.globalIrqEnable && (epTxRxFlag || missedFrameStartFlag)) |-> irqSource)
      else $error("Enabled source did not raise interrupt");

   global_off_a: assert property ( // [RL3]
      (!ctrlFf.globalIrqEnable) |-> !irqSource)
      else $error("Interrupt raised with global enable clear");

   read_data_a: assert property (
      (rdAccess && haddr[7:0] == SYS_STATUS_ADDR) |=> (hrdata[7:0] == $past(statusByte)))
      else $error("Status read data wrong");

endmodule : usic_irq_suspend_control

//--- usic_usb_side.sv
// USB side event source model driving the block's bus event inputs
`timescale 1ns/1ps
module usic_usb_side
(
   input wire logic sys_clk,
   input wire logic epReq,
   input wire logic missReq,
   input wire logic rstReq,
   input wire logic suspReq,
   output logic epTxRxFlag,
   output logic missedFrameStartFlag,
   output logic usbResetDetect,
   output logic suspendCondition
);
   initial
   begin
      epTxRxFlag = 1'b0;
      missedFrameStartFlag = 1'b0;
      usbResetDetect = 1'b0;
      suspendCondition = 1'b0;
   end
   always @(posedge sys_clk)
   begin
      epTxRxFlag <= epReq;
      missedFrameStartFlag <= missReq;
      usbResetDetect <= rstReq & !usbResetDetect; // One-cycle bus reset event
      suspendCondition <= suspReq;
   end
endmodule : usic_usb_side

//--- usic_irq_suspend_control_tb.sv
// Self-checking testbench for the interrupt and suspend control block
`timescale 1ns/1ps
module usic_irq_suspend_control_tb;
   import usic_pkg::*;
   logic sys_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic hreadyout, hresp, pin, sysIrq, pwrOff, suspCmd, ep, miss, rst, susp;
   logic epReq = 1'b0, missReq = 1'b0, rstReq = 1'b0, suspReq = 1'b0;
   int err_count = 0, checks = 0, cnt, seed = 32'h3db2;
   always #12.5 sys_clk = ~sys_clk;
   usic_usb_side i_usb (.sys_clk(sys_clk), .epReq(epReq), .missReq(missReq), .rstReq(rstReq),
      .suspReq(suspReq), .epTxRxFlag(ep), .missedFrameStartFlag(miss),
      .usbResetDetect(rst), .suspendCondition(susp));
   usic_irq_suspend_control i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .epTxRxFlag(ep), .missedFrameStartFlag(miss),
      .usbResetDetect(rst), .suspendCondition(susp), .interruptOutputPin(pin),
      .sysIrq(sysIrq), .suspendPowerOff(pwrOff), .suspendCommand(suspCmd));
   function automatic logic [31:0] ctrlExp(input logic [31:0] v);
      ctrlExp = {24'h0, v[7:0] & 8'hb6};
   endfunction : ctrlExp
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      hsize <= HSIZE_WORD;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask : xfer
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(d, exp);
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask : rdChk
   task automatic pinChk(input logic exp, input logic irq);
      @(negedge sys_clk);
      chk({30'h0, pin, sysIrq}, {30'h0, exp, irq});
      @(posedge sys_clk);
   endtask : pinChk
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      conclude();
   end
   initial
   begin
      cyc(3);
      sys_rst <= 1'b0;
      cyc(2);
      rdChk(SYS_STATUS_ADDR, 32'h0);
      rdChk(SYS_CTRL_ADDR, 32'h0);
      rdChk(8'h80, 32'h0);
      xfer(1'b1, SYS_STATUS_ADDR, 32'h10); // Power-off first set at start
      cyc(1);
      chk({31'h0, pwrOff}, 32'h1);
      repeat (4)
      begin
         cnt = $random(seed);
         xfer(1'b1, SYS_CTRL_ADDR, cnt & 32'hffff_fffe); // Reserved bit written as zero
         rdChk(SYS_CTRL_ADDR, ctrlExp(cnt));
      end
      xfer(1'b1, SYS_STATUS_ADDR, 32'h0c); // Detect disable set, reserved bit 2 written as one
      rdChk(SYS_STATUS_ADDR, 32'h08);
      suspReq <= 1'b1;
      cyc(4);
      rdChk(SYS_STATUS_ADDR, 32'h08);
      xfer(1'b1, SYS_STATUS_ADDR, 32'h10); // Detect disable cleared
      cyc(2);
      rdChk(SYS_STATUS_ADDR, 32'h12);
      suspReq <= 1'b0;
      cyc(2);
      rdChk(INT_STATUS_ADDR, 32'h2);
      xfer(1'b1, SYS_STATUS_ADDR, 32'h12); // Suspend after power-off is set
      xfer(1'b1, SYS_STATUS_ADDR, 32'h10);
      @(negedge sys_clk);
      chk({31'h0, suspCmd}, 32'h1);
      @(negedge sys_clk);
      chk({31'h0, suspCmd}, 32'h0);
      @(posedge sys_clk);
      xfer(1'b1, SYS_CTRL_ADDR, 32'h02);
      for (int i = 0; i < 2; i++)
      begin
         epReq <= (i == 0);
         missReq <= (i == 1);
         cyc(2);
         pinChk(1'b0, 1'b0);
         epReq <= 1'b0;
         missReq <= 1'b0;
         cyc(2);
         pinChk(1'b1, 1'b0);
      end
      xfer(1'b1, SYS_CTRL_ADDR, 32'h82);
      epReq <= 1'b1;
      cyc(2);
      pinChk(1'b1, 1'b0);
      epReq <= 1'b0;
      xfer(1'b1, SYS_CTRL_ADDR, 32'h86);
      cyc(2);
      cnt = $random(seed);
      epReq <= cnt[0];
      missReq <= !cnt[0];
      for (int i = 0; i < 10; i++)
      begin
         @(negedge sys_clk);
         cnt = (i == 0) ? 0 : cnt;
         cnt += (pin === 1'b1);
      end
      chk(cnt, 32'h2);
      @(posedge sys_clk);
      epReq <= 1'b0;
      missReq <= 1'b0;
      xfer(1'b1, SYS_CTRL_ADDR, 32'h12);
      xfer(1'b1, INT_MASK_ADDR, 32'h1);
      rstReq <= 1'b1;
      @(posedge sys_clk);
      rstReq <= 1'b0;
      cyc(3);
      pinChk(1'b0, 1'b1);
      rdChk(SYS_STATUS_ADDR, 32'h11);
      rdChk(INT_STATUS_ADDR, 32'h1);
      pinChk(1'b0, 1'b0);
      xfer(1'b1, SYS_STATUS_ADDR, 32'h10);
      cyc(2);
      pinChk(1'b1, 1'b0);
      rdChk(SYS_STATUS_ADDR, 32'h10);
      conclude();
   end
endmodule : usic_irq_suspend_control_tb
